/* logic/scpg_top.v */
// Split cycle 8-bit PWM generator with shared port pin control
`timescale 1ns/1ps
// Overview of operation
// - One PWM cycle is 256 PWM clocks, total high time equals duty value.
// - PWM clock is system clock, system clock over four, or slow RC clock.
// - 6+2 mode splits the cycle into four 64-clock sub-cycles 0..3.
// - 6+2 mode: duty bits 7..2 are base part, bits 1..0 extra count.
// - 6+2 sub-cycles below extra count are high base+1 clocks, others base.
// - 7+1 mode splits the cycle into two 128-clock sub-cycles 0 and 1.
// - 7+1 mode: duty bits 7..1 are base part, bit 0 extra count.
// - 7+1 sub-cycle below extra count high base+1 clocks, otherwise base.
// - Hardware splits sub-cycles; software only writes duty and control.
// - Control register bit 5 set selects 7+1 mode.
// - Control register bit 3 set routes PWM onto the shared output pin.
// - Routed, pin output: data high drives PWM, data low forces low.
// - Routed, pin input: ordinary input line with pull-high option kept.
`include "scpg_defines.vh"

module scpg_top (
    input  wire       i_sys_clk,
    input  wire       i_rst,
    input  wire       i_duty_wr,
    input  wire [7:0] i_duty_wdata,
    input  wire       i_ctrl_wr,
    input  wire [7:0] i_ctrl_wdata,
    input  wire [1:0] i_clk_src_sel,
    input  wire       i_slow_rc_clock,
    input  wire       i_port_dir,
    input  wire       i_port_a_data,
    input  wire       i_pull_high_opt,
    input  wire       i_pin_in,
    output reg  [7:0] o_duty_value,
    output reg  [7:0] o_system_control_reg,
    output reg        o_pwm_wave,
    output reg        o_pin_out,
    output reg        o_pin_oe_n,
    output reg        o_pull_high_en,
    output reg        o_pin_in_value
);

    reg  [7:0] duty_shadow;
    reg  [7:0] pwm_count;
    reg  [1:0] div4_count;
    reg        rc_meta;
    reg        rc_sync;
    reg        rc_prev;
    reg        pin_meta;
    reg        pwm_tick;
    reg        next_tick;
    wire       mode_7p1;
    wire       pin_sel;
    wire       wave_high;

    // High while the position is below base plus an earned extra clock
    function wave_level;
        input [7:0] count;
        input [7:0] duty;
        input       is_7p1;
        reg   [6:0] position;
        reg   [7:0] limit;
        begin
            position = 7'h00;
            limit    = 8'h00;
            if (is_7p1) begin
                // Bit 7 picks one of two 128-clock sub-cycles
                position = count[6:0];
                limit    = {1'b0, duty[7:1]}
                         + {7'h00, (count[7] < duty[0])};
            end else begin
                // Bits 7..6 pick one of four 64-clock sub-cycles
                position = {1'b0, count[5:0]};
                limit    = {2'b00, duty[7:2]}
                         + {7'h00, (count[7:6] < duty[1:0])};
            end
            // Limit tops out at 128 or 64, so eight bits never wrap
            wave_level = {1'b0, position} < limit;
        end
    endfunction

    assign mode_7p1  =
        o_system_control_reg[`SCPG_CTRL_MODE_BIT];
    assign pin_sel   =
        o_system_control_reg[`SCPG_CTRL_PINSEL_BIT];
    // Strict less-than gives base time when index equals extra count
    assign wave_high =
        wave_level(pwm_count, duty_shadow, mode_7p1);

    // Duty register, writable at any time
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_duty_value <= `SCPG_DUTY_RESET;
        end else if (i_duty_wr) begin
            o_duty_value <= i_duty_wdata;
        end
    end

    // Control register; only mode and pin routing bits act, rest stored
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_system_control_reg <= `SCPG_CTRL_RESET;
        end else if (i_ctrl_wr) begin
            o_system_control_reg <= i_ctrl_wdata;
        end
    end

    // Slow RC crosses in through two flops before the edge detect
    // Edge detect reads the second flop and its delayed copy, never the first
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            rc_meta <= 1'b0;
            rc_sync <= 1'b0;
            rc_prev <= 1'b0;
        end else begin
            rc_meta <= i_slow_rc_clock;
            rc_sync <= rc_meta;
            rc_prev <= rc_sync;
        end
    end

    // Pin level crosses in through two flops
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            pin_meta       <= 1'b0;
            o_pin_in_value <= 1'b0;
        end else begin
            pin_meta       <= i_pin_in;
            o_pin_in_value <= pin_meta;
        end
    end

    // PWM clock enable from the selected source; code 3 stops the count
    always @* begin
        case (i_clk_src_sel)
            `SCPG_CLKSRC_SYS: begin
                next_tick = 1'b1;
            end
            `SCPG_CLKSRC_SYS_DIV4: begin
                next_tick = (div4_count == `SCPG_DIV4_LAST);
            end
            `SCPG_CLKSRC_SLOW_RC: begin
                next_tick = rc_sync & ~rc_prev;
            end
            default: begin
                next_tick = 1'b0;
            end
        endcase
    end

    // Free-running quarter-rate divider; its phase is not tied to writes
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            div4_count <= 2'h0;
        end else begin
            div4_count <= div4_count + 2'h1;
        end
    end

    // Tick is registered, so the count steps one clock after the decoded source edge
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            pwm_tick <= 1'b0;
        end else begin
            pwm_tick <= next_tick;
        end
    end

    // 256-step cycle counter, one step per PWM clock
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            pwm_count <= 8'h00;
        end else if (pwm_tick) begin
            pwm_count <= pwm_count + 8'h01;
        end
    end

    // Duty taken only at the wrap, so one cycle never mixes two values
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            duty_shadow <= `SCPG_DUTY_RESET;
        end else if (pwm_tick && (pwm_count == `SCPG_CYCLE_LAST)) begin
            duty_shadow <= o_duty_value;
        end
    end

    // Ungated waveform, one clock behind the count
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_pwm_wave <= 1'b0;
        end else begin
            o_pwm_wave <= wave_high;
        end
    end

    // Port data bit doubles as the on/off switch of the routed waveform
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_pin_out <= 1'b0;
        end else if (pin_sel) begin
            o_pin_out <= i_port_a_data & wave_high;
        end else begin
            o_pin_out <= i_port_a_data;
        end
    end

    // Direction bit alone decides driving, routed or not
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_pin_oe_n <= 1'b1;
        end else begin
            o_pin_oe_n <= i_port_dir;
        end
    end

    // Pull-high only matters while the pin listens as an input
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_pull_high_en <= 1'b0;
        end else begin
            o_pull_high_en <= i_port_dir & i_pull_high_opt;
        end
    end

endmodule

/* shared/scpg_defines.vh */
// Constants for the split cycle PWM generator
`ifndef SCPG_DEFINES_VH
`define SCPG_DEFINES_VH

// System control register bit positions
`define SCPG_CTRL_MODE_BIT     5
`define SCPG_CTRL_PINSEL_BIT   3

// Reset values
`define SCPG_DUTY_RESET        8'h00
`define SCPG_CTRL_RESET        8'h00

// PWM clock source encodings
`define SCPG_CLKSRC_SYS        2'h0
`define SCPG_CLKSRC_SYS_DIV4   2'h1
`define SCPG_CLKSRC_SLOW_RC    2'h2

// Timing counts: divider in system clocks, cycle in PWM clocks
`define SCPG_DIV4_LAST         2'h3
`define SCPG_CYCLE_LAST        8'hFF

`endif

/* verif/scpg_cpu.sv */
// CPU side model that writes the PWM registers
`timescale 1ns/1ps
module scpg_cpu (
    input  wire       i_sys_clk,
    output reg        o_dw = 1'b0,
    output reg        o_cw = 1'b0,
    output reg  [7:0] o_d  = 8'h00
);
    task wr(input logic c, input logic [7:0] d);
        @(posedge i_sys_clk);
        o_dw <= !c;
        o_cw <= c;
        o_d <= d;
        @(posedge i_sys_clk);
        {o_dw, o_cw} <= 2'h0;
        // Stale data must not look valid
        o_d <= ~d;
    endtask
endmodule

/* verif/scpg_sva.sv */
// Port assertions for the PWM generator
`timescale 1ns/1ps
module scpg_sva (
    input wire       i_sys_clk,
    input wire       i_rst,
    input wire       i_duty_wr,
    input wire [7:0] i_duty_wdata,
    input wire       i_ctrl_wr,
    input wire [7:0] i_ctrl_wdata,
    input wire [1:0] i_clk_src_sel,
    input wire       i_port_dir,
    input wire       i_port_a_data,
    input wire       i_pull_high_opt,
    input wire       i_pin_in,
    input wire [7:0] o_duty_value,
    input wire [7:0] o_system_control_reg,
    input wire       o_pwm_wave,
    input wire       o_pin_out,
    input wire       o_pin_oe_n,
    input wire       o_pull_high_en,
    input wire       o_pin_in_value
);
    // Masks the first edge after reset
    reg rdy = 1'b0;
    always @(posedge i_sys_clk) rdy <= !i_rst;
    // Two-flop input path needs two clean edges behind it
    reg rdy2 = 1'b0;
    always @(posedge i_sys_clk) rdy2 <= rdy && !i_rst;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    property p_dw; i_duty_wr |=> o_duty_value == $past(i_duty_wdata);
    endproperty
    a_dw: assert property (p_dw) else $error("duty wr");
    property p_dh; !i_duty_wr |=> $stable(o_duty_value); endproperty
    a_dh: assert property (p_dh) else $error("duty hold");
    property p_cw; i_ctrl_wr |=> o_system_control_reg == $past(i_ctrl_wdata);
    endproperty
    a_cw: assert property (p_cw) else $error("ctrl wr");
    property p_oe; rdy |-> o_pin_oe_n == $past(i_port_dir); endproperty
    a_oe: assert property (p_oe) else $error("dir");
    property p_ph;
        rdy |-> o_pull_high_en == $past(i_port_dir & i_pull_high_opt);
    endproperty
    a_ph: assert property (p_ph) else $error("pull");
    property p_in; rdy2 |-> o_pin_in_value == $past(i_pin_in, 2); endproperty
    a_in: assert property (p_in) else $error("pin in");
    property p_st; i_clk_src_sel == 2'h3 [*4] |=> $stable(o_pwm_wave);
    endproperty
    a_st: assert property (p_st) else $error("stop");
    // Pin and wave flops load together, so the wave is not delayed here
    property p_po;
        rdy |-> o_pin_out == ($past(i_port_a_data)
            & ($past(!o_system_control_reg[3]) | o_pwm_wave));
    endproperty
    a_po: assert property (p_po) else $error("pin");
endmodule

/* verif/scpg_tb_top.sv */
// Self-checking bench for the PWM generator
`timescale 1ns/1ps
module scpg_tb_top;
    logic       i_sys_clk = 0, i_rst = 1, i_port_dir = 1, i_port_a_data = 0;
    logic       i_pull_high_opt = 0, i_slow_rc_clock = 0;
    logic [1:0] i_clk_src_sel = 2'h0;
    int         bad_count = 0, checked = 0, rc_edges = 0, rc_base = 0;
    wire        i_duty_wr, i_ctrl_wr, i_pin_in, o_pwm_wave, o_pin_out;
    wire        o_pin_oe_n, o_pull_high_en, o_pin_in_value;
    wire  [7:0] i_duty_wdata, i_ctrl_wdata, o_duty_value;
    wire  [7:0] o_system_control_reg;
    assign i_ctrl_wdata = i_duty_wdata;
    assign i_pin_in = i_slow_rc_clock;
    initial forever #12.5 i_sys_clk = ~i_sys_clk;
    always #510 i_slow_rc_clock = ~i_slow_rc_clock;
    always @(posedge i_slow_rc_clock) rc_edges++;
    scpg_cpu cpu (.i_sys_clk, .o_dw(i_duty_wr), .o_cw(i_ctrl_wr),
        .o_d(i_duty_wdata));
    scpg_top uut (.*);
    task chk(input string n, input logic [9:0] e, s);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s exp %0d got %0d", n, e, s);
        end
    endtask
    task run(input logic [7:0] v, input logic m, input int k);
        int hi, t, ln, sum, per;
        per = m ? 128 : 64;
        ln = 0;
        sum = 0;
        cpu.wr(1, {2'h0, m, 5'h08});
        cpu.wr(0, v);
        // Lets the new duty reach a fresh cycle
        repeat (600 * k) @(negedge i_sys_clk);
        @(posedge o_pwm_wave);
        @(negedge i_sys_clk);
        repeat (256 / per) begin
            hi = 0;
            while (o_pwm_wave) begin
                hi++;
                @(negedge i_sys_clk);
            end
            t = hi;
            while (!o_pwm_wave) begin
                t++;
                @(negedge i_sys_clk);
            end
            chk("period", per * k, t);
            sum += hi;
            ln += (hi == k * ((m ? v[7:1] : v[7:2]) + 1));
        end
        chk("high", v * k, sum);
        chk("extra", m ? v[0] : v[1:0], ln);
        $display("test %h done", v);
    endtask
    task test_done;
        $display("checks %0d errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_rst <= 0;
        @(negedge i_sys_clk);
        chk("duty", 0, o_duty_value);
        chk("ctrl", 0, o_system_control_reg);
        $display("test reset done");
        @(posedge i_sys_clk);
        i_port_dir <= 0;
        i_port_a_data <= 1;
        run(8'h05, 0, 1);
        run(8'h4B, 0, 1);
        run(8'h64, 1, 1);
        run(8'h65, 1, 1);
        @(posedge i_sys_clk);
        i_clk_src_sel <= 2'h1;
        run(8'h4B, 0, 4);
        @(posedge i_sys_clk);
        i_clk_src_sel <= 2'h3;
        i_port_a_data <= 0;
        repeat (20) @(posedge i_sys_clk);
        i_port_dir <= 1;
        i_pull_high_opt <= 1;
        i_clk_src_sel <= 2'h2;
        // One sub-cycle must take one step per slow RC rising edge
        @(posedge o_pwm_wave);
        rc_base = rc_edges;
        @(posedge o_pwm_wave);
        chk("rc ticks", 64, rc_edges - rc_base);
        $display("test slow rc done");
        repeat (900) @(posedge i_sys_clk);
        test_done;
    end
    initial begin
        #1000000;
        bad_count++;
        test_done;
    end
endmodule
bind scpg_top scpg_sva u_sva (.*);
